// ### hdl/ciot_defs.vh
// Register map, field codes and timing constants of the camera I/O line block
`ifndef CIOT_DEFS_VH
`define CIOT_DEFS_VH
// Register word byte addresses
`define CIOT_CTRL_ADDR 12'h000
`define CIOT_LINE_ADDR 12'h004
`define CIOT_DEB_ADDR 12'h008
`define CIOT_WAIT_ADDR 12'h00C
`define CIOT_DUR_ADDR 12'h010
`define CIOT_STAT_ADDR 12'h014
// Line register fields
`define CIOT_LINE_DIR_BIT 0
`define CIOT_LINE_FLIP_BIT 1
`define CIOT_LINE_ORIG_LSB 4
// Control register fields
`define CIOT_CTRL_PICK_BIT 0
`define CIOT_CTRL_SOFT_BIT 1
`define CIOT_CTRL_RESTART_BIT 2
`define CIOT_CTRL_TSRC_LSB 4
`define CIOT_CTRL_TACT_LSB 8
// Output origin codes
`define CIOT_ORIG_OFF 3'h0
`define CIOT_ORIG_SHUTTER 3'h1
`define CIOT_ORIG_READOUT 3'h2
`define CIOT_ORIG_SOFT 3'h3
`define CIOT_ORIG_PULSE 3'h4
// Timer trigger source codes
`define CIOT_TSRC_OFF 2'h0
`define CIOT_TSRC_SHUTTER 2'h1
`define CIOT_TSRC_READOUT 2'h2
`define CIOT_TSRC_FIRST_IO_CHANNEL 2'h3
// Timer fire condition codes
`define CIOT_TACT_RISE 2'h0
`define CIOT_TACT_FALL 2'h1
`define CIOT_TACT_HIGH 2'h2
`define CIOT_TACT_LOW 2'h3
// Timing
`define CIOT_CLK_MHZ 40
`define CIOT_US_CYCLES (`CIOT_CLK_MHZ)
`define CIOT_DEB_RESET_US 32'h0000_0001
`define CIOT_DUR_RESET_US 32'h0000_0001
`define CIOT_WAIT_RESET_US 32'h0000_0000
`define CIOT_DEB_MAX_US 32'd1000000
`define CIOT_TIME_MAX_US 32'd60000000
`endif

// ### hdl/ciot_top.v
// Camera digital I/O lines with glitch filter and pulse generator
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Channel pick selects which line is configured
// - Each line configurable as input or output
// - Polarity flip inverts chosen output origin
// - Origin off disables line output drive
// - Shutter origin follows exposure window
// - Readout origin follows frame readout window
// - Soft origin drives software level value
// - Pulse origin drives timer output
// - Filter accepts levels stable for span
// - Filtered change lags input by span
// - Edge modes pulse lasts programmed duration
// - Timer waits programmed delay before active
// - Restart command clears timer back to idle
// - Trigger source off/shutter/readout/first line
// - Edge modes fire on chosen edge
// - Level modes active while source level holds
// - High mode: delay then follow source high
//////////////////////////////////////////////////////////////////////////////
`include "ciot_defs.vh"
module ciot_top #(
    parameter US_CYCLES = `CIOT_US_CYCLES
) (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire shutter_window_i,
    input wire readout_window_i,
    input wire first_io_channel_i,
    input wire second_io_channel_i,
    output reg first_io_channel_o,
    output reg first_io_channel_oe_o,
    output reg second_io_channel_o,
    output reg second_io_channel_oe_o,
    output reg first_io_channel_filt_o,
    output reg second_io_channel_filt_o,
    output reg pulse_gen_origin_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_ACT = 2'h2;
    localparam ST_DONE = 2'h3;

    reg io_channel_pick_q;
    reg soft_level_value_q;
    reg [1:0] pulse_gen_origin_pick_q;
    reg [1:0] pulse_gen_fire_condition_q;
    reg [1:0] io_direction_q;
    reg [1:0] output_polarity_flip_q;
    reg [2:0] output_origin_pick_q [0:1];
    reg [31:0] glitch_filter_span_q;
    reg [31:0] pulse_gen_wait_q;
    reg [31:0] pulse_dur_q;
    reg restart_q;
    reg [15:0] tick_cnt_q;
    reg tick_q;
    reg [1:0] pin_s1_q;
    reg [1:0] pin_s2_q;
    reg [1:0] filt_q;
    reg [31:0] deb_cnt_q [0:1];
    reg [1:0] tst_q;
    reg [31:0] tm_cnt_q;
    reg src_q;
    reg shut_s1_q;
    reg shut_s2_q;
    reg rd_s1_q;
    reg rd_s2_q;
    reg [1:0] tst_d;
    reg [31:0] tm_cnt_d;
    reg fire;
    reg hold;
    reg src;
    wire apb_wr;
    wire sel;
    wire wait_done;
    wire dur_done;

    assign apb_wr = psel_i & penable_i & pwrite_i;
    assign sel = io_channel_pick_q;
    // The tick runs free, so one tick more than programmed is counted:
    // no interval comes out short, at the cost of up to 1 us too long
    assign wait_done = (pulse_gen_wait_q == 32'h0000_0000) ||
        (tm_cnt_q > pulse_gen_wait_q);
    assign dur_done = (tm_cnt_q > pulse_dur_q);

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            io_channel_pick_q <= 1'b0;
            soft_level_value_q <= 1'b0;
            pulse_gen_origin_pick_q <= `CIOT_TSRC_OFF;
            pulse_gen_fire_condition_q <= `CIOT_TACT_RISE;
            io_direction_q <= 2'b00;
            output_polarity_flip_q <= 2'b00;
            output_origin_pick_q[0] <= `CIOT_ORIG_OFF;
            output_origin_pick_q[1] <= `CIOT_ORIG_OFF;
            glitch_filter_span_q <= `CIOT_DEB_RESET_US;
            pulse_gen_wait_q <= `CIOT_WAIT_RESET_US;
            pulse_dur_q <= `CIOT_DUR_RESET_US;
            restart_q <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            restart_q <= 1'b0;
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
            if (apb_wr) begin
                case (paddr_i)
                `CIOT_CTRL_ADDR: begin
                    io_channel_pick_q <= pwdata_i[`CIOT_CTRL_PICK_BIT];
                    soft_level_value_q <= pwdata_i[`CIOT_CTRL_SOFT_BIT];
                    restart_q <= pwdata_i[`CIOT_CTRL_RESTART_BIT];
                    pulse_gen_origin_pick_q <=
                        pwdata_i[`CIOT_CTRL_TSRC_LSB +: 2];
                    pulse_gen_fire_condition_q <=
                        pwdata_i[`CIOT_CTRL_TACT_LSB +: 2];
                end
                `CIOT_LINE_ADDR: begin
                    io_direction_q[sel] <= pwdata_i[`CIOT_LINE_DIR_BIT];
                    output_polarity_flip_q[sel] <=
                        pwdata_i[`CIOT_LINE_FLIP_BIT];
                    output_origin_pick_q[sel] <=
                        pwdata_i[`CIOT_LINE_ORIG_LSB +: 3];
                end
                `CIOT_DEB_ADDR:
                    glitch_filter_span_q <=
                        (pwdata_i > `CIOT_DEB_MAX_US) ?
                        `CIOT_DEB_MAX_US : pwdata_i;
                `CIOT_WAIT_ADDR:
                    pulse_gen_wait_q <= (pwdata_i > `CIOT_TIME_MAX_US) ?
                        `CIOT_TIME_MAX_US : pwdata_i;
                `CIOT_DUR_ADDR: begin
                    // Zero duration is not allowed; it reads back as one
                    if (pwdata_i == 32'h0000_0000)
                        pulse_dur_q <= 32'h0000_0001;
                    else if (pwdata_i > `CIOT_TIME_MAX_US)
                        pulse_dur_q <= `CIOT_TIME_MAX_US;
                    else
                        pulse_dur_q <= pwdata_i;
                end
                `CIOT_STAT_ADDR: ;
                default: ;
                endcase
            end
            if (psel_i & ~penable_i) begin
                prdata_o <= 32'h0000_0000;
                case (paddr_i)
                `CIOT_CTRL_ADDR:
                    prdata_o <= {22'h0, pulse_gen_fire_condition_q, 2'h0,
                        pulse_gen_origin_pick_q, 2'h0, soft_level_value_q,
                        io_channel_pick_q};
                `CIOT_LINE_ADDR:
                    prdata_o <= {25'h0, output_origin_pick_q[sel], 2'h0,
                        output_polarity_flip_q[sel], io_direction_q[sel]};
                `CIOT_DEB_ADDR: prdata_o <= glitch_filter_span_q;
                `CIOT_WAIT_ADDR: prdata_o <= pulse_gen_wait_q;
                `CIOT_DUR_ADDR: prdata_o <= pulse_dur_q;
                `CIOT_STAT_ADDR:
                    prdata_o <= {26'h0, tst_q, pulse_gen_origin_o,
                        src_q, filt_q};
                // Unmapped words answer with an error for both directions
                default: pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Microsecond tick and pin synchronisers
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
            pin_s1_q <= 2'b00;
            pin_s2_q <= 2'b00;
            shut_s1_q <= 1'b0;
            shut_s2_q <= 1'b0;
            rd_s1_q <= 1'b0;
            rd_s2_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == US_CYCLES - 1);
            if (tick_cnt_q == US_CYCLES - 1)
                tick_cnt_q <= 16'h0000;
            else
                tick_cnt_q <= tick_cnt_q + 16'h0001;
            pin_s1_q <= {second_io_channel_i, first_io_channel_i};
            pin_s2_q <= pin_s1_q;
            shut_s1_q <= shutter_window_i;
            shut_s2_q <= shut_s1_q;
            rd_s1_q <= readout_window_i;
            rd_s2_q <= rd_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Glitch filters: a level is taken once it held for the whole span,
    // so every accepted change lags its arrival by that span
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_filt
            always @(posedge sys_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    deb_cnt_q[g] <= 32'h0000_0000;
                    filt_q[g] <= 1'b0;
                end else if (pin_s2_q[g] == filt_q[g]) begin
                    deb_cnt_q[g] <= 32'h0000_0000;
                end else if (glitch_filter_span_q == 32'h0000_0000 ||
                        deb_cnt_q[g] > glitch_filter_span_q) begin
                    filt_q[g] <= pin_s2_q[g];
                    deb_cnt_q[g] <= 32'h0000_0000;
                end else if (tick_q) begin
                    deb_cnt_q[g] <= deb_cnt_q[g] + 32'h0000_0001;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pulse generator
    always @* begin
        case (pulse_gen_origin_pick_q)
        `CIOT_TSRC_SHUTTER: src = shut_s2_q;
        `CIOT_TSRC_READOUT: src = rd_s2_q;
        `CIOT_TSRC_FIRST_IO_CHANNEL: src = filt_q[0];
        default: src = 1'b0;
        endcase
        case (pulse_gen_fire_condition_q)
        `CIOT_TACT_RISE: begin fire = src & ~src_q; hold = 1'b0; end
        `CIOT_TACT_FALL: begin fire = ~src & src_q; hold = 1'b0; end
        `CIOT_TACT_HIGH: begin fire = src; hold = 1'b1; end
        default: begin fire = ~src; hold = 1'b1; end
        endcase
        if (pulse_gen_origin_pick_q == `CIOT_TSRC_OFF)
            fire = 1'b0;
        tst_d = tst_q;
        tm_cnt_d = tm_cnt_q;
        case (tst_q)
        ST_IDLE:
            if (fire) begin
                tst_d = ST_WAIT;
                tm_cnt_d = 32'h0000_0000;
            end
        ST_WAIT:
            if (hold && !fire) begin
                tst_d = ST_IDLE;
            end else if (wait_done) begin
                tst_d = ST_ACT;
                tm_cnt_d = 32'h0000_0000;
            end else if (tick_q) begin
                tm_cnt_d = tm_cnt_q + 32'h0000_0001;
            end
        ST_ACT:
            if (hold) begin
                if (!fire)
                    tst_d = ST_IDLE;
            end else if (dur_done) begin
                tst_d = ST_IDLE;
            end else if (tick_q) begin
                tm_cnt_d = tm_cnt_q + 32'h0000_0001;
            end
        default: tst_d = ST_IDLE;
        endcase
        if (restart_q) begin
            tst_d = ST_IDLE;
            tm_cnt_d = 32'h0000_0000;
        end
    end

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tst_q <= ST_IDLE;
            tm_cnt_q <= 32'h0000_0000;
            src_q <= 1'b0;
            pulse_gen_origin_o <= 1'b0;
        end else begin
            tst_q <= tst_d;
            tm_cnt_q <= tm_cnt_d;
            src_q <= src;
            pulse_gen_origin_o <= (tst_d == ST_ACT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output origin mux, polarity flip and drive enable per line
    reg [1:0] org;
    reg [1:0] oen;
    integer k;
    always @* begin
        for (k = 0; k < 2; k = k + 1) begin
            oen[k] = io_direction_q[k];
            case (output_origin_pick_q[k])
            `CIOT_ORIG_SHUTTER: org[k] = shut_s2_q;
            `CIOT_ORIG_READOUT: org[k] = rd_s2_q;
            `CIOT_ORIG_SOFT: org[k] = soft_level_value_q;
            `CIOT_ORIG_PULSE: org[k] = (tst_d == ST_ACT);
            default: begin
                org[k] = 1'b0;
                oen[k] = 1'b0;
            end
            endcase
            org[k] = org[k] ^ output_polarity_flip_q[k];
        end
    end

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            first_io_channel_o <= 1'b0;
            first_io_channel_oe_o <= 1'b0;
            second_io_channel_o <= 1'b0;
            second_io_channel_oe_o <= 1'b0;
            first_io_channel_filt_o <= 1'b0;
            second_io_channel_filt_o <= 1'b0;
        end else begin
            first_io_channel_o <= org[0];
            first_io_channel_oe_o <= oen[0];
            second_io_channel_o <= org[1];
            second_io_channel_oe_o <= oen[1];
            first_io_channel_filt_o <= filt_q[0] & ~io_direction_q[0];
            second_io_channel_filt_o <= filt_q[1] & ~io_direction_q[1];
        end
    end
endmodule // ciot_top

// ### sim/ciot_top_asserts.sv
// Port checker for the camera I/O line block
`timescale 1ns/1ps
module ciot_top_asserts (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire shutter_window_i,
    input wire readout_window_i,
    input wire first_io_channel_i,
    input wire second_io_channel_i,
    input wire first_io_channel_o,
    input wire first_io_channel_oe_o,
    input wire second_io_channel_o,
    input wire second_io_channel_oe_o,
    input wire first_io_channel_filt_o,
    input wire second_io_channel_filt_o,
    input wire pulse_gen_origin_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    //////////////////////////////////////////////////////////////////////////
    a_rdy_after_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_rdy_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_rdy_in_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access");
    a_idle_no_rdy: assert property (!psel_i |=> !pready_o)
        else $error("ready without select");
    a_err_with_rdy: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_rdata_hold: assert property (!(psel_i && !penable_i) |=>
        $stable(prdata_o))
        else $error("read data moved outside setup");
    // Sync plus output stage: a level accepted now was present 3 and 4 back
    // A rise caused by turning a driven line into an input is no acceptance
    a_filt0_stable: assert property ($rose(first_io_channel_filt_o) &&
        !$past(first_io_channel_oe_o) |->
        $past(first_io_channel_i, 3) && $past(first_io_channel_i, 4))
        else $error("first line accepted unstable high");
    a_filt1_stable: assert property ($rose(second_io_channel_filt_o) &&
        !$past(second_io_channel_oe_o) |->
        $past(second_io_channel_i, 3) && $past(second_io_channel_i, 4))
        else $error("second line accepted unstable high");
    a_out_filt_zero: assert property (second_io_channel_oe_o &&
        $past(second_io_channel_oe_o) |-> !second_io_channel_filt_o)
        else $error("filtered level on driven line");
    c_err: cover property (pready_o && pslverr_o);
    c_pulse: cover property ($rose(pulse_gen_origin_o));
    c_drive: cover property (second_io_channel_oe_o);
endmodule // ciot_top_asserts

bind ciot_top ciot_top_asserts ciot_top_asserts_inst (.sys_clk_i, .reset_n_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .shutter_window_i, .readout_window_i, .first_io_channel_i,
    .second_io_channel_i, .first_io_channel_o, .first_io_channel_oe_o,
    .second_io_channel_o, .second_io_channel_oe_o, .first_io_channel_filt_o,
    .second_io_channel_filt_o, .pulse_gen_origin_o);

// ### sim/ciot_partner.sv
// Model of the frame sources and the equipment on the two lines
`timescale 1ns/1ps
module ciot_partner (
    input wire sys_clk_i,
    input wire go_i,
    input wire lvl0_i,
    input wire lvl1_i,
    input wire o0_i,
    input wire oe0_i,
    input wire o1_i,
    input wire oe1_i,
    output wire shutter_o,
    output wire readout_o,
    output wire pin0_o,
    output wire pin1_o
);
    int n = 0;
    // One frame per request: 20 cycles exposure, then 20 cycles readout
    always @(posedge sys_clk_i) begin
        if (go_i)
            n <= 1;
        else if (n != 0 && n < 41)
            n <= n + 1;
        else
            n <= 0;
    end
    assign shutter_o = n >= 1 && n <= 20;
    assign readout_o = n >= 21 && n <= 40;
    // The device wins the wire while it drives
    assign pin0_o = oe0_i ? o0_i : lvl0_i;
    assign pin1_o = oe1_i ? o1_i : lvl1_i;
endmodule // ciot_partner

// ### sim/ciot_top_tb.sv
// Self-checking bench for the camera I/O line block
`timescale 1ns/1ps
`include "ciot_defs.vh"
module ciot_top_tb;
    logic sys_clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0;
    logic pwrite_i = 0, go = 0, lvl0 = 0, lvl1 = 0, err;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, rd;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, sh, ro, p0, p1, o0, oe0, o1, oe1, f0, f1, tmr;
    int bad_count = 0, n_tests = 0, c, w;
    ciot_top #(.US_CYCLES(4)) ciot_top_inst (.sys_clk_i, .reset_n_i,
        .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .shutter_window_i(sh), .readout_window_i(ro),
        .first_io_channel_i(p0), .second_io_channel_i(p1),
        .first_io_channel_o(o0), .first_io_channel_oe_o(oe0),
        .second_io_channel_o(o1), .second_io_channel_oe_o(oe1),
        .first_io_channel_filt_o(f0), .second_io_channel_filt_o(f1),
        .pulse_gen_origin_o(tmr));
    ciot_partner ciot_partner_inst (.sys_clk_i, .go_i(go), .lvl0_i(lvl0),
        .lvl1_i(lvl1), .o0_i(o0), .oe0_i(oe0), .o1_i(o1), .oe1_i(oe1),
        .shutter_o(sh), .readout_o(ro), .pin0_o(p0), .pin1_o(p1));
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    //////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chb(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rng(input int v, input int lo, input int hi);
        n_tests++;
        if (v < lo || v > hi) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h..%h", $time, v, lo, hi);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic frame;
        @(posedge sys_clk_i);
        go <= 1;
        @(posedge sys_clk_i);
        go <= 0;
    endtask
    // Select 0 waits on the timer output, any other on the first filter
    task automatic upto(input int s, input logic v, output int n);
        n = 0;
        while ((s == 0 ? tmr : f0) !== v && n < 300) begin
            @(posedge sys_clk_i);
            n++;
        end
    endtask
    //////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rdc(`CIOT_DEB_ADDR, 32'h1);
        rdc(`CIOT_WAIT_ADDR, 32'h0);
        rdc(`CIOT_DUR_ADDR, 32'h1);
        rdc(12'h020, 32'h0);
        chb(err, 1'b1);
        apb(1, 12'h020, 32'hFFFF_FFFF);
        chb(err, 1'b1);
    endtask
    task automatic t_line;
        apb(1, `CIOT_CTRL_ADDR, 32'h3);
        rdc(`CIOT_CTRL_ADDR, 32'h3);
        apb(1, `CIOT_LINE_ADDR, 32'h31);
        cyc(3);
        chk(32'({oe1, o1, oe0}), 32'h6);
        apb(1, `CIOT_LINE_ADDR, 32'h33);
        cyc(3);
        chb(o1, 1'b0);
        apb(1, `CIOT_LINE_ADDR, 32'h01);
        cyc(3);
        chb(oe1, 1'b0);
        apb(1, `CIOT_LINE_ADDR, 32'h11);
        frame;
        cyc(8);
        chb(o1, 1'b1);
        cyc(20);
        chb(o1, 1'b0);
        apb(1, `CIOT_LINE_ADDR, 32'h21);
        frame;
        cyc(30);
        chb(o1, 1'b1);
        cyc(20);
        chb(o1, 1'b0);
        apb(1, `CIOT_LINE_ADDR, 32'h0);
        lvl1 <= 1;
        cyc(15);
        chb(f1, 1'b1);
    endtask
    // Span of 2 us is 8 cycles; a 5 cycle glitch must not pass
    task automatic t_deb;
        apb(1, `CIOT_DEB_ADDR, 32'h2);
        apb(1, `CIOT_CTRL_ADDR, 32'h30);
        lvl0 <= 1;
        cyc(5);
        lvl0 <= 0;
        cyc(20);
        chb(f0, 1'b0);
        lvl0 <= 1;
        upto(1, 1, c);
        rng(c, 11, 17);
        upto(0, 1, c);
        rng(c, 0, 8);
    endtask
    task automatic t_tmr(input logic [31:0] ctl, input logic [31:0] wt,
                         input logic [31:0] du, input int lo, input int hi,
                         input int wlo, input int whi);
        apb(1, `CIOT_CTRL_ADDR, ctl);
        apb(1, `CIOT_WAIT_ADDR, wt);
        apb(1, `CIOT_DUR_ADDR, du);
        cyc(10);
        frame;
        upto(0, 1, c);
        rng(c, lo, hi);
        upto(0, 0, w);
        rng(w, wlo, whi);
    endtask
    // First line driven by the timer origin, so its pin follows the pulse
    task automatic t_restart;
        apb(1, `CIOT_CTRL_ADDR, 32'h10);
        apb(1, `CIOT_DUR_ADDR, 32'h14);
        apb(1, `CIOT_LINE_ADDR, 32'h41);
        frame;
        upto(0, 1, c);
        chb(o0, 1'b1);
        apb(1, `CIOT_CTRL_ADDR, 32'h14);
        cyc(2);
        chb(tmr, 1'b0);
        chb(o0, 1'b0);
        cyc(20);
        chb(tmr, 1'b0);
        rdc(`CIOT_CTRL_ADDR, 32'h10);
        rdc(`CIOT_STAT_ADDR, 32'h2);
    endtask
    // Mid-run reset while the timer is active: everything returns to idle
    task automatic t_rst;
        apb(1, `CIOT_CTRL_ADDR, 32'h310);
        cyc(5);
        chb(tmr, 1'b1);
        reset_n_i <= 0;
        cyc(2);
        chb(tmr, 1'b0);
        chb(oe0, 1'b0);
        reset_n_i <= 1;
        rdc(`CIOT_CTRL_ADDR, 32'h0);
        chb(tmr, 1'b0);
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge sys_clk_i);
        reset_n_i <= 1;
        t_regs;
        t_line;
        t_deb;
        t_tmr(32'h10, 32'h2, 32'h3, 8, 17, 12, 17);
        t_tmr(32'h120, 32'h0, 32'h1, 40, 49, 4, 9);
        t_tmr(32'h210, 32'h1, 32'h1, 4, 13, 7, 20);
        t_tmr(32'h310, 32'h0, 32'h1, 0, 0, 1, 6);
        t_tmr(32'h0, 32'h0, 32'h1, 300, 300, 0, 0);
        t_restart;
        t_rst;
        close_out;
    end
    // Whole run needs about 20 us; 150 us means a hang
    initial begin
        #150us;
        bad_count++;
        close_out;
    end
endmodule // ciot_top_tb
